// ### ch_cam_housekeeping.sv
`timescale 1ns/1ps
`include "ch_defines.svh"

// How it works
// - delete trigger removes entry matching staged address
// - set-address trigger loads stage word zero
// - read trigger loads page from stage zero
// - read result fills four stage words
// - read copies status halves to two registers
// - status bits 29-28 give entry validity
// - entry address advances after every read
// - current stamp offered to lookup datapath
// - purge increments counter, then deletes matches
// - stamp trigger increments current counter only
// - purge trigger increments and deletes matches
// - combined routine by register or hardware input
// - purges never remove permanent entries
// - both counters eight bits and wrap
// - full cam drives interrupt when enabled
// - status bit zero shows cam_full_n level, set while not full

module ch_cam_housekeeping (
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   input  wire logic          port_select_n,
   input  wire logic          write_n,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [15:0]   reg_data_in,
   output logic [15:0]        reg_data_out,
   output logic               reg_data_oe,
   input  wire logic          hw_increment_in,
   input  wire logic          cfg_hw_hw_increment_in_en,
   input  wire logic          cfg_full_interrupt_out_n_en,
   input  wire logic          cam_full_n,
   output logic               interrupt_out_n,
   output logic               cam_cmd_valid,
   input  wire logic          cam_cmd_ready,
   output ch_pkg::ch_op_t     cam_cmd_op,
   output logic [63:0]        cam_cmd_data,
   output logic [15:0]        cam_cmd_mask,
   input  wire logic          cam_rsp_valid,
   input  wire logic [63:0]   cam_rsp_entry,
   input  wire logic [31:0]   cam_rsp_status,
   output logic [7:0]         current_stamp,
   output logic               busy
);
   import ch_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [27:0] pin_m_q;
   logic [27:0] pin_s_q;
   logic        wr_prev_q;
   logic        hw_prev_q;

   wire        sel_level  = !pin_s_q[1];
   wire        wr_level   = sel_level && !pin_s_q[0];
   wire        rd_level   = sel_level && pin_s_q[0];
   wire [15:0] wdata      = pin_s_q[17:2];
   wire [7:0]  waddr      = pin_s_q[25:18];
   wire        full_n_s   = pin_s_q[26];
   wire        hw_level   = pin_s_q[27];
   // one strobe per host write cycle, however long it is held
   wire        wr_stb     = wr_level && !wr_prev_q;
   wire        hw_rise    = hw_level && !hw_prev_q;

   // reset to idle pin levels: deselected, not full, no request,
   // so no false full interrupt right after reset
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         pin_m_q   <= 28'h400_0003;
         pin_s_q   <= 28'h400_0003;
         wr_prev_q <= 1'b0;
         hw_prev_q <= 1'b0;
      end
      else
      begin
         pin_m_q   <= {hw_increment_in, cam_full_n, reg_addr,
                       reg_data_in, port_select_n, write_n};
         pin_s_q   <= pin_m_q;
         wr_prev_q <= wr_level;
         hw_prev_q <= hw_level;
      end
   end

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic      [15:0] stage_q [4];
   logic      [15:0] stat_hi_q;
   logic      [15:0] stat_lo_q;
   logic      [15:0] page_q;
   logic      [15:0] addr_q;
   ch_state_t        state_q;
   ch_state_t        state_d;
   ch_op_t           op_q;
   logic             idle;

   assign idle = state_q == CH_ST_IDLE;

   // triggers arriving while a routine runs are dropped
   wire go_del   = wr_stb && idle && waddr == `CH_ADDR_DELETE;
   wire go_read  = wr_stb && idle && waddr == `CH_ADDR_READ;
   wire go_setad = wr_stb && idle && waddr == `CH_ADDR_SET_ADDR;
   wire go_incts = wr_stb && idle && waddr == `CH_ADDR_INC_STAMP;
   wire go_incpr = wr_stb && idle && waddr == `CH_ADDR_INC_PURGE;
   wire go_both  = idle && ((wr_stb && waddr == `CH_ADDR_INC_BOTH)
                  || (cfg_hw_hw_increment_in_en && hw_rise));
   wire go_purge = go_incpr || go_both;
   wire go_any   = go_del || go_read || go_setad || go_purge;
   wire rsp_take = state_q == CH_ST_WAIT && cam_rsp_valid;

   // ------------------------------------------------------------
   // stamp counters
   // ------------------------------------------------------------
   logic [7:0] purge_stamp;

   ch_stamp_counters u_counters (
      .ref_clk       (ref_clk),
      .rstn          (rstn),
      .inc_current   (go_incts || go_both),
      .inc_purge     (go_purge),
      .current_stamp (current_stamp),
      .purge_stamp   (purge_stamp)
   );

   // ------------------------------------------------------------
   // stage words
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_stage
         wire host_wr = wr_stb && idle
                        && waddr == 8'(`CH_ADDR_STAGE0 + gi);
         always_ff @(posedge ref_clk)
         begin
            if (!rstn)
               stage_q[gi] <= `CH_ZERO16;
            else if (rsp_take)
               stage_q[gi] <= cam_rsp_entry[16*gi +: 16];
            else if (host_wr)
               stage_q[gi] <= wdata;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // address, page and status registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         page_q    <= `CH_ZERO16;
         addr_q    <= `CH_ZERO16;
         stat_hi_q <= `CH_ZERO16;
         stat_lo_q <= `CH_ZERO16;
      end
      else
      begin
         if (go_setad)
            addr_q <= stage_q[0];
         else if (rsp_take)
            addr_q <= 16'(addr_q + 16'h0001);
         if (go_read)
            page_q <= stage_q[0];
         if (rsp_take)
         begin
            stat_hi_q <= cam_rsp_status[31:16];
            stat_lo_q <= cam_rsp_status[15:0];
         end
      end
   end

   // ------------------------------------------------------------
   // routine sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         CH_ST_IDLE:
            if (go_any)
               state_d = CH_ST_ISSUE;
         CH_ST_ISSUE:
            if (cam_cmd_ready)
               state_d = op_q == CH_OP_READ ? CH_ST_WAIT : CH_ST_IDLE;
         CH_ST_WAIT:
            if (cam_rsp_valid)
               state_d = CH_ST_IDLE;
         default:
            state_d = CH_ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         state_q <= CH_ST_IDLE;
         op_q    <= CH_OP_DELETE;
      end
      else
      begin
         state_q <= state_d;
         if (go_del)
            op_q <= CH_OP_DELETE;
         else if (go_read)
            op_q <= CH_OP_READ;
         else if (go_setad)
            op_q <= CH_OP_SET_ADDR;
         else if (go_purge)
            op_q <= CH_OP_PURGE;
      end
   end

   // ------------------------------------------------------------
   // cam command
   // ------------------------------------------------------------
   // staged words carry the more significant byte on the low lane
   wire [47:0] mac = {stage_q[2][7:0], stage_q[2][15:8],
                      stage_q[1][7:0], stage_q[1][15:8],
                      stage_q[0][7:0], stage_q[0][15:8]};
   // purge compares the new purge stamp with the permanent bit clear
   wire [63:0] purge_key = {48'h0, 1'b0, 7'h00, purge_stamp};

   always_comb
   begin
      case (op_q)
         CH_OP_DELETE:   cam_cmd_data = {16'h0, mac};
         CH_OP_SET_ADDR: cam_cmd_data = {48'h0, addr_q};
         CH_OP_READ:     cam_cmd_data = {32'h0, page_q, addr_q};
         CH_OP_PURGE:    cam_cmd_data = purge_key;
         default:        cam_cmd_data = 64'h0;
      endcase
   end

   assign cam_cmd_valid = state_q == CH_ST_ISSUE;
   assign cam_cmd_op    = op_q;
   assign cam_cmd_mask  = op_q == CH_OP_PURGE ?
                          `CH_PURGE_MASK : `CH_ZERO16;
   assign busy          = !idle;

   // ------------------------------------------------------------
   // host read port
   // ------------------------------------------------------------
   logic [15:0] rdata_q;
   logic        roe_q;
   logic        int_q;
   logic [15:0] rd_mux;
   wire  [15:0] sys_status = {15'h0, full_n_s};

   always_comb
   begin
      case (waddr)
         `CH_ADDR_SYS_STATUS: rd_mux = sys_status;
         `CH_ADDR_STAGE0:     rd_mux = stage_q[0];
         `CH_ADDR_STAGE1:     rd_mux = stage_q[1];
         `CH_ADDR_STAGE2:     rd_mux = stage_q[2];
         `CH_ADDR_STAGE3:     rd_mux = stage_q[3];
         `CH_ADDR_STAT_HIGH:  rd_mux = stat_hi_q;
         `CH_ADDR_STAT_LOW:   rd_mux = stat_lo_q;
         default:             rd_mux = `CH_ZERO16;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         rdata_q <= `CH_ZERO16;
         roe_q   <= 1'b0;
         int_q   <= 1'b0;
      end
      else
      begin
         rdata_q <= rd_mux;
         roe_q   <= rd_level;
         int_q   <= cfg_full_interrupt_out_n_en && !full_n_s;
      end
   end

   assign reg_data_out    = rdata_q;
   assign reg_data_oe     = roe_q;
   assign interrupt_out_n = !int_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_delete_issues: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      go_del |=> cam_cmd_valid && cam_cmd_op == CH_OP_DELETE
                 && cam_cmd_data[47:0] == $past(mac))
      else $error("delete trigger did not issue delete");

   chk_setaddr_load: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      go_setad |=> addr_q == $past(stage_q[0]))
      else $error("set address did not load address");

   chk_page_load: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      go_read |=> page_q == $past(stage_q[0]) && cam_cmd_valid)
      else $error("read trigger did not load page");

   chk_read_fill: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      rsp_take |=> stage_q[3] == $past(cam_rsp_entry[63:48])
                   && stage_q[0] == $past(cam_rsp_entry[15:0]))
      else $error("read result not placed in stage words");

   chk_status_copy: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      rsp_take |=> {stat_hi_q, stat_lo_q} == $past(cam_rsp_status))
      else $error("status not copied");

   chk_addr_advance: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      rsp_take |=> addr_q == 16'($past(addr_q) + 16'h0001))
      else $error("entry address did not advance");

   chk_purge_key: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      go_purge ##1 cam_cmd_valid |-> cam_cmd_op == CH_OP_PURGE
         && cam_cmd_data[7:0] == 8'($past(purge_stamp) + 8'h01)
         && !cam_cmd_data[`CH_PERM_BIT]
         && cam_cmd_mask == `CH_PURGE_MASK)
      else $error("purge key wrong");

   chk_hw_gate: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      idle && hw_rise && !cfg_hw_hw_increment_in_en && !wr_stb |=> idle)
      else $error("hardware increment ran while disabled");

   chk_stamp_only: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      go_incts |=> idle && current_stamp
                   == 8'($past(current_stamp) + 8'h01))
      else $error("stamp increment misbehaved");

   chk_full_interrupt_out_n: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      cfg_full_interrupt_out_n_en && !full_n_s |=> !interrupt_out_n)
      else $error("full cam did not interrupt");

endmodule // ch_cam_housekeeping

// ### ch_cam_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// behavioural cam: prompt or slow accept, delayed read answer
// ------------------------------------------------------------
module ch_cam_model (
   input  wire logic            ref_clk,
   input  wire logic            rstn,
   input  wire logic            slow,
   input  wire logic            cam_cmd_valid,
   output logic                 cam_cmd_ready,
   input  wire ch_pkg::ch_op_t  cam_cmd_op,
   input  wire logic [63:0]     cam_cmd_data,
   input  wire logic [15:0]     cam_cmd_mask,
   output logic                 cam_rsp_valid,
   output logic [63:0]          cam_rsp_entry,
   output logic [31:0]          cam_rsp_status,
   output ch_pkg::ch_op_t       last_op,
   output logic [63:0]          last_data,
   output logic [15:0]          last_mask,
   output logic [7:0]           cmd_count
);
   import ch_pkg::*;

   logic [1:0]  wait_q;
   logic [2:0]  rsp_cnt_q;
   logic        rsp_q;
   logic [15:0] addr_q;
   logic [63:0] entry;

   assign cam_cmd_ready = cam_cmd_valid && (wait_q == (slow ? 2'h3 : 2'h0));
   // permanent bit set in every stored entry
   assign entry = {addr_q, ~addr_q, addr_q ^ 16'h5a5a,
                   16'h8000 | addr_q};
   // outside the answer pulse the lines show junk, never the last value
   assign cam_rsp_valid  = rsp_q;
   assign cam_rsp_entry  = rsp_q ? entry : ~entry;
   assign cam_rsp_status = rsp_q ? {16'h3000, addr_q} : {16'hcfff, ~addr_q};

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         wait_q    <= 2'h0;
         rsp_cnt_q <= 3'h0;
         rsp_q     <= 1'b0;
         addr_q    <= 16'h0000;
         cmd_count <= 8'h00;
         last_op   <= CH_OP_DELETE;
         last_data <= 64'h0;
         last_mask <= 16'h0000;
      end
      else
      begin
         wait_q <= (cam_cmd_valid && !cam_cmd_ready) ? wait_q + 2'h1 : 2'h0;
         rsp_q  <= (rsp_cnt_q == 3'h1);
         if (rsp_cnt_q != 3'h0)
            rsp_cnt_q <= rsp_cnt_q - 3'h1;
         if (cam_cmd_valid && cam_cmd_ready)
         begin
            last_op   <= cam_cmd_op;
            last_data <= cam_cmd_data;
            last_mask <= cam_cmd_mask;
            cmd_count <= cmd_count + 8'h01;
            if (cam_cmd_op == CH_OP_READ)
            begin
               addr_q    <= cam_cmd_data[15:0];
               rsp_cnt_q <= slow ? 3'h5 : 3'h2;
            end
         end
      end
   end
endmodule // ch_cam_model

// ### ch_defines.svh
`ifndef CH_DEFINES_SVH
`define CH_DEFINES_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CH_ADDR_SYS_STATUS   8'h00
`define CH_ADDR_STAGE0       8'h05
`define CH_ADDR_STAGE1       8'h06
`define CH_ADDR_STAGE2       8'h07
`define CH_ADDR_STAGE3       8'h08
`define CH_ADDR_STAT_HIGH    8'h0d
`define CH_ADDR_STAT_LOW     8'h0e
`define CH_ADDR_DELETE       8'h20
`define CH_ADDR_READ         8'h24
`define CH_ADDR_INC_STAMP    8'h26
`define CH_ADDR_INC_PURGE    8'h27
`define CH_ADDR_INC_BOTH     8'h28
`define CH_ADDR_SET_ADDR     8'h29

// ------------------------------------------------------------
// field positions and values
// ------------------------------------------------------------
`define CH_FULL_BIT          0
`define CH_PERM_BIT          15
`define CH_VALID_HI          29
`define CH_VALID_LO          28
`define CH_PURGE_MASK        16'h80ff
`define CH_ZERO16            16'h0000
`define CH_STAMP_RESET       8'h00
`define CH_PURGE_RESET       8'h00

`endif

// ### ch_pkg.sv
package ch_pkg;

   typedef enum logic [2:0] {
      CH_OP_DELETE,
      CH_OP_SET_ADDR,
      CH_OP_READ,
      CH_OP_PURGE
   } ch_op_t;

   typedef enum {
      CH_ST_IDLE,
      CH_ST_ISSUE,
      CH_ST_WAIT
   } ch_state_t;

endpackage

// ### ch_stamp_counters.sv
`timescale 1ns/1ps
`include "ch_defines.svh"

module ch_stamp_counters (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       inc_current,
   input  wire logic       inc_purge,
   output logic [7:0]      current_stamp,
   output logic [7:0]      purge_stamp
);
   import ch_pkg::*;

   logic [7:0] cur_q;
   logic [7:0] cur_d;
   logic [7:0] pur_q;
   logic [7:0] pur_d;

   // ------------------------------------------------------------
   // wrapping counters
   // ------------------------------------------------------------
   // plain 8-bit adds wrap, so any gap of 1..255 is reachable
   assign cur_d = inc_current ? 8'(cur_q + 8'h01) : cur_q;
   assign pur_d = inc_purge ? 8'(pur_q + 8'h01) : pur_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         cur_q <= `CH_STAMP_RESET;
         pur_q <= `CH_PURGE_RESET;
      end
      else
      begin
         cur_q <= cur_d;
         pur_q <= pur_d;
      end
   end

   assign current_stamp = cur_q;
   assign purge_stamp   = pur_q;

   chk_cur_wraps: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      inc_current |=> cur_q == 8'($past(cur_q) + 8'h01))
      else $error("current stamp did not step by one");

   chk_pur_holds: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      !inc_purge |=> $stable(pur_q))
      else $error("purge stamp moved without request");

endmodule // ch_stamp_counters

// ### testbench.sv
`timescale 1ns/1ps

module testbench;
   import ch_pkg::*;

   logic         ref_clk, rstn, port_select_n, write_n, slow;
   logic [7:0]   reg_addr;
   logic [15:0]  reg_data_in, reg_data_out, last_mask;
   logic         reg_data_oe, hw_increment_in, cfg_hw_hw_increment_in_en;
   logic         cfg_full_interrupt_out_n_en, cam_full_n, interrupt_out_n, busy;
   logic         cam_cmd_valid, cam_cmd_ready, cam_rsp_valid;
   ch_op_t       cam_cmd_op, last_op;
   logic [63:0]  cam_cmd_data, cam_rsp_entry, last_data;
   logic [15:0]  cam_cmd_mask;
   logic [31:0]  cam_rsp_status;
   logic [7:0]   current_stamp, cmd_count, cnt0;
   logic [15:0]  a;
   int           errors, tests_run;

   ch_cam_housekeeping dut (
      .ref_clk          (ref_clk),
      .rstn             (rstn),
      .port_select_n    (port_select_n),
      .write_n          (write_n),
      .reg_addr         (reg_addr),
      .reg_data_in      (reg_data_in),
      .reg_data_out     (reg_data_out),
      .reg_data_oe      (reg_data_oe),
      .hw_increment_in  (hw_increment_in),
      .cfg_hw_hw_increment_in_en   (cfg_hw_hw_increment_in_en),
      .cfg_full_interrupt_out_n_en (cfg_full_interrupt_out_n_en),
      .cam_full_n       (cam_full_n),
      .interrupt_out_n  (interrupt_out_n),
      .cam_cmd_valid    (cam_cmd_valid),
      .cam_cmd_ready    (cam_cmd_ready),
      .cam_cmd_op       (cam_cmd_op),
      .cam_cmd_data     (cam_cmd_data),
      .cam_cmd_mask     (cam_cmd_mask),
      .cam_rsp_valid    (cam_rsp_valid),
      .cam_rsp_entry    (cam_rsp_entry),
      .cam_rsp_status   (cam_rsp_status),
      .current_stamp    (current_stamp),
      .busy             (busy)
   );

   ch_cam_model cam (
      .ref_clk          (ref_clk),
      .rstn             (rstn),
      .slow             (slow),
      .cam_cmd_valid    (cam_cmd_valid),
      .cam_cmd_ready    (cam_cmd_ready),
      .cam_cmd_op       (cam_cmd_op),
      .cam_cmd_data     (cam_cmd_data),
      .cam_cmd_mask     (cam_cmd_mask),
      .cam_rsp_valid    (cam_rsp_valid),
      .cam_rsp_entry    (cam_rsp_entry),
      .cam_rsp_status   (cam_rsp_status),
      .last_op          (last_op),
      .last_data        (last_data),
      .last_mask        (last_mask),
      .cmd_count        (cmd_count)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------------------
   // host bus tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] expv);
      tests_run++;
      if (seen !== expv)
      begin
         errors++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, expv);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [15:0] d);
      int n;
      @(posedge ref_clk);
      port_select_n <= 1'b0;
      write_n       <= 1'b0;
      reg_addr      <= ad;
      reg_data_in   <= d;
      repeat (4) @(posedge ref_clk);
      port_select_n <= 1'b1;
      write_n       <= 1'b1;
      reg_data_in   <= ~d;
      repeat (4) @(posedge ref_clk);
      n = 0;
      // no busy poll over the bus, so watch the pin with a bound
      while (busy !== 1'b0 && n < 60)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk(busy, 1'b0);
   endtask

   task automatic rd(input logic [7:0] ad, input logic [15:0] expv);
      @(posedge ref_clk);
      port_select_n <= 1'b0;
      write_n       <= 1'b1;
      reg_addr      <= ad;
      repeat (5) @(posedge ref_clk);
      #1;
      chk(reg_data_oe, 1'b1);
      chk(reg_data_out, expv);
      @(posedge ref_clk);
      port_select_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic hw_pulse;
      @(posedge ref_clk);
      hw_increment_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      hw_increment_in <= 1'b0;
      repeat (20) @(posedge ref_clk);
      #1;
   endtask

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      wrap_up;
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial
   begin
      errors = 0;
      tests_run = 0;
      rstn = 1'b0;
      port_select_n = 1'b1;
      write_n = 1'b1;
      reg_addr = 8'h00;
      reg_data_in = 16'h0000;
      hw_increment_in = 1'b0;
      cfg_hw_hw_increment_in_en = 1'b1;
      cfg_full_interrupt_out_n_en = 1'b0;
      cam_full_n = 1'b1;
      slow = 1'b0;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(8'h00, 16'h0001);
      rd(8'h40, 16'h0000);
      chk(interrupt_out_n, 1'b1);
      $display("test reset done");

      wr(8'h07, 16'h6002);
      wr(8'h06, 16'h128c);
      wr(8'h05, 16'h5634);
      rd(8'h07, 16'h6002);
      wr(8'h20, 16'hbeef);
      chk(last_op, CH_OP_DELETE);
      chk(last_data, 64'h0000_0260_8c12_3456);
      $display("test delete done");

      slow <= 1'b1;
      wr(8'h05, 16'h0012);
      wr(8'h29, 16'h0000);
      chk(last_op, CH_OP_SET_ADDR);
      chk(last_data, 64'h12);
      for (int k = 0; k < 2; k++)
      begin
         a = 16'h0012 + 16'(k);
         wr(8'h05, 16'h0000);
         wr(8'h24, 16'hffff);
         chk(last_op, CH_OP_READ);
         chk(last_data, {48'h0, a});
         rd(8'h08, a);
         rd(8'h07, ~a);
         rd(8'h06, a ^ 16'h5a5a);
         rd(8'h05, 16'h8000 | a);
         rd(8'h0d, 16'h3000);
         rd(8'h0e, a);
      end
      slow <= 1'b0;
      $display("test entry read done");

      cnt0 = cmd_count;
      wr(8'h26, 16'h0000);
      wr(8'h26, 16'h0000);
      chk(current_stamp, 8'h02);
      chk(cmd_count, cnt0);
      wr(8'h27, 16'h0000);
      chk(last_op, CH_OP_PURGE);
      chk(last_data, 64'h01);
      chk(last_mask, 16'h80ff);
      chk(current_stamp, 8'h02);
      wr(8'h28, 16'h0000);
      chk(current_stamp, 8'h03);
      chk(last_data, 64'h02);
      hw_pulse;
      chk(current_stamp, 8'h04);
      chk(last_data, 64'h03);
      cnt0 = cmd_count;
      cfg_hw_hw_increment_in_en <= 1'b0;
      hw_pulse;
      chk(current_stamp, 8'h04);
      chk(cmd_count, cnt0);
      $display("test counters done");

      // current runs 4 up through ff and back to 00, purge stays 03
      repeat (252) wr(8'h26, 16'h0000);
      chk(current_stamp, 8'h00);
      $display("test wrap done");

      cfg_full_interrupt_out_n_en <= 1'b1;
      cam_full_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk(interrupt_out_n, 1'b0);
      rd(8'h00, 16'h0000);
      wr(8'h27, 16'h0000);
      chk(last_data, 64'h04);
      cam_full_n <= 1'b1;
      rd(8'h00, 16'h0001);
      chk(interrupt_out_n, 1'b1);
      cfg_full_interrupt_out_n_en <= 1'b0;
      cam_full_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk(interrupt_out_n, 1'b1);
      $display("test full flag done");
      wrap_up;
   end
endmodule // testbench
